//--- rtl/cdp_axi_regs.sv
`timescale 1ns/1ps
module cdp_axi_regs (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  cdp_regs_if.slave_side rif // engine side
);
  import cdp_pkg::*;
  logic aw_held, w_held;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;
  logic [31:0] control;
  wire do_write = aw_held && w_held && !bvalid;
  wire [31:0] strobed = {s_q[3] ? w_q[31:24] : 8'h00, s_q[2] ? w_q[23:16] : 8'h00,
                         s_q[1] ? w_q[15:8] : 8'h00, s_q[0] ? w_q[7:0] : 8'h00};
  wire [31:0] byte_mask = {{8{s_q[3]}}, {8{s_q[2]}}, {8{s_q[1]}}, {8{s_q[0]}}};
  wire [31:0] merge_ctl = (control & ~byte_mask) | strobed;
  wire wr_hit = aw_q == OFS_CONTROL || aw_q == OFS_BASE || aw_q == OFS_POLL ||
                aw_q == OFS_STATUS || aw_q == OFS_CURRENT;
  wire [31:0] status_word = {30'h0000_0000, rif.error, rif.busy};
  wire rd_hit = araddr == OFS_CONTROL || araddr == OFS_BASE || araddr == OFS_POLL ||
                araddr == OFS_STATUS || araddr == OFS_CURRENT;
  wire [31:0] rd_mux = araddr == OFS_CONTROL ? control :
                       araddr == OFS_BASE ? rif.base :
                       araddr == OFS_CURRENT ? rif.current :
                       araddr == OFS_POLL ? {16'h0000, rif.poll} :
                       araddr == OFS_STATUS ? status_word : 32'h0000_0000;
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign rif.enable = control[CTL_ENABLE_BIT];
  assign rif.receive = control[CTL_RECEIVE_BIT];
  // error is write-one-to-clear on the status word
  assign rif.error_clear = do_write && aw_q == OFS_STATUS && strobed[ST_ERROR_BIT];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      s_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
      control <= 32'h0000_0000;
      rif.base <= RST_BASE;
      rif.poll <= RST_POLL;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_q <= wdata;
        s_q <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? 2'h0 : 2'h2;
        if (aw_q == OFS_CONTROL) control <= {30'h0000_0000, merge_ctl[1:0]};
        if (aw_q == OFS_BASE) rif.base <= (rif.base & ~byte_mask) | strobed;
        if (aw_q == OFS_POLL) rif.poll <= {s_q[1] ? w_q[15:8] : rif.poll[15:8],
                                          s_q[0] ? w_q[7:0] : rif.poll[7:0]};
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule : cdp_axi_regs

//--- rtl/cdp_pkg.sv
package cdp_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_BASE = 8'h04;
  localparam logic [7:0] OFS_CURRENT = 8'h08;
  localparam logic [7:0] OFS_POLL = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // control and status bit positions
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_RECEIVE_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERROR_BIT = 1;
  // reset values
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam logic [15:0] RST_POLL = 16'h0000;
  // descriptor control word fields
  localparam int OWN_BIT = 31;
  localparam int MODE_HI = 29;
  localparam int MODE_LO = 27;
  localparam int FETCH_BIT = 22;
  localparam int CHAIN_BIT = 19;
  localparam int FRAME_BIT = 18;
  localparam int PKT_IRQ_BIT = 17;
  localparam int DESC_IRQ_BIT = 16;
  localparam int LEN_HI = 15;
  // descriptor word order in memory
  localparam int DESC_WORDS = 8;
  localparam logic [2:0] W_CTRL = 3'h0;
  localparam logic [2:0] W_ASSOC = 3'h1;
  localparam logic [2:0] W_SRC = 3'h2;
  localparam logic [2:0] W_DST = 3'h3;
  localparam logic [2:0] W_NEXT = 3'h4;
  localparam logic [2:0] W_POST = 3'h5;
  localparam logic [2:0] W_MSG = 3'h6;
  localparam logic [2:0] W_COFF = 3'h7;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_PREBOOT = 3'b001,
    MODE_KEY_WRAP = 3'b010,
    MODE_CONTENT_KEY = 3'b011
  } crypto_operation_type;
endpackage : cdp_pkg

//--- rtl/cdp_regs_if.sv
`timescale 1ns/1ps
interface cdp_regs_if;
  logic enable;
  logic receive;
  logic [31:0] base;
  logic [15:0] poll;
  logic error_clear;
  logic busy;
  logic error;
  logic [31:0] current;
  modport slave_side(output enable, receive, base, poll, error_clear,
                     input busy, error, current);
  modport engine_side(input enable, receive, base, poll, error_clear,
                      output busy, error, current);
endinterface : cdp_regs_if

//--- rtl/crypto_descriptor_processor.sv
`timescale 1ns/1ps
// Overview of operation
// - bit 31 set hands descriptor to engine
// - engine clears ownership after finishing descriptor
// - mode field 29:27 decoded into four operations
// - fetch flag loads association from pointer
// - fetch flag clear reuses last association
// - bit 19 marks chain end, else follow next
// - after chain end reload address from base
// - receive writes frame-final flag bit 18
// - packet interrupt when enabled and packet ends
// - descriptor interrupt when enabled, every descriptor
// - receive overwrites length with filled bytes
// - linked list, fields updated in place
// - association pointer addresses keys and vectors
// - unowned descriptor waits poll cycles, refetches
// - results posted at result-posting pointer
module crypto_descriptor_processor (
  input wire logic clock, // system clock, 250 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] awaddr, // axi write address
  input wire logic awvalid, // axi write address valid
  output logic awready, // axi write address ready
  input wire logic [31:0] wdata, // axi write data
  input wire logic [3:0] wstrb, // axi byte strobes
  input wire logic wvalid, // axi write data valid
  output logic wready, // axi write data ready
  output logic [1:0] bresp, // axi write response
  output logic bvalid, // axi write response valid
  input wire logic bready, // axi write response ready
  input wire logic [7:0] araddr, // axi read address
  input wire logic arvalid, // axi read address valid
  output logic arready, // axi read address ready
  output logic [31:0] rdata, // axi read data
  output logic [1:0] rresp, // axi read response
  output logic rvalid, // axi read data valid
  input wire logic rready, // axi read data ready
  output logic mem_valid, // memory request
  output logic mem_write, // memory request is a write
  output logic [31:0] mem_addr, // memory byte address
  output logic [31:0] mem_wdata, // memory write data
  input wire logic mem_ready, // request taken, read data valid
  input wire logic [31:0] mem_rdata, // memory read data
  output logic op_start, // one-cycle start to the datapath
  output cdp_pkg::crypto_operation_type op_mode, // decoded operation
  output logic op_fetch_association, // load association before run
  output logic [31:0] op_association_pointer, // association address
  output logic [31:0] op_source_pointer, // source buffer
  output logic [31:0] op_destination_pointer, // destination buffer
  output logic [15:0] op_buffer_length, // buffer size
  output logic [31:0] op_total_message_bytes, // total message length
  output logic [31:0] op_cipher_offset, // cipher offset
  input wire logic op_done, // datapath finished
  input wire logic [15:0] op_filled_bytes, // bytes filled on receive
  input wire logic op_frame_end, // receive buffer ended the frame
  input wire logic [31:0] op_result, // result word to post
  output logic descriptor_done_irq, // one-cycle event
  output logic packet_done_irq // one-cycle event
);
  import cdp_pkg::*;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FETCH_CTRL = 3'b001,
    S_POLL = 3'b010,
    S_FETCH_REST = 3'b011,
    S_RUN = 3'b100,
    S_POST = 3'b101,
    S_WRITE_BACK = 3'b110
  } state_type;

  state_type state;
  logic [31:0] desc [DESC_WORDS];
  logic [31:0] cur_addr;
  logic [2:0] idx;
  logic [15:0] poll_cnt;
  logic error;
  logic [15:0] filled;
  logic frame_end;
  logic [31:0] result;
  cdp_regs_if rif();

  cdp_axi_regs u_regs (
    .clock(clock),
    .rst_n(rst_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rif(rif.slave_side)
  );

  wire [31:0] ctrl = desc[W_CTRL];
  wire owned = mem_rdata[OWN_BIT];
  // top bit of the mode field set means a reserved code
  wire mode_reserved = mem_rdata[MODE_HI];
  wire chain_end = ctrl[CHAIN_BIT];
  wire packet_end = rif.receive ? frame_end : ctrl[FRAME_BIT];
  wire last_word = idx == W_COFF;
  wire [31:0] word_addr = cur_addr + {27'h000_0000, idx, 2'b00};
  // ownership returned, frame flag and length refreshed on receive
  wire [31:0] wb_word = {1'b0, ctrl[30:19],
                         rif.receive ? frame_end : ctrl[FRAME_BIT],
                         ctrl[PKT_IRQ_BIT:DESC_IRQ_BIT],
                         rif.receive ? filled : ctrl[LEN_HI:0]};
  wire [31:0] next_addr = chain_end ? rif.base : desc[W_NEXT];

  assign mem_valid = state == S_FETCH_CTRL || state == S_FETCH_REST ||
                     state == S_POST || state == S_WRITE_BACK;
  assign mem_write = state == S_POST || state == S_WRITE_BACK;
  assign mem_addr = state == S_POST ? desc[W_POST] : word_addr;
  assign mem_wdata = state == S_POST ? result : wb_word;
  assign op_mode = crypto_operation_type'(ctrl[MODE_HI:MODE_LO]);
  assign op_fetch_association = ctrl[FETCH_BIT];
  assign op_association_pointer = desc[W_ASSOC];
  assign op_source_pointer = desc[W_SRC];
  assign op_destination_pointer = desc[W_DST];
  assign op_buffer_length = ctrl[LEN_HI:0];
  assign op_total_message_bytes = desc[W_MSG];
  assign op_cipher_offset = desc[W_COFF];
  assign rif.busy = state != S_IDLE;
  assign rif.error = error;
  assign rif.current = cur_addr;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DESC_WORDS; i++) desc[i] <= 32'h0000_0000;
    end else if (mem_valid && !mem_write && mem_ready) begin
      desc[idx] <= mem_rdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      cur_addr <= RST_BASE;
      idx <= W_CTRL;
      poll_cnt <= 16'h0000;
      error <= 1'b0;
      filled <= 16'h0000;
      frame_end <= 1'b0;
      result <= 32'h0000_0000;
      op_start <= 1'b0;
      descriptor_done_irq <= 1'b0;
      packet_done_irq <= 1'b0;
    end else begin
      op_start <= 1'b0;
      descriptor_done_irq <= 1'b0;
      packet_done_irq <= 1'b0;
      // a new reserved-mode fault in the same cycle beats the clear
      if (rif.error_clear) error <= 1'b0;
      case (state)
        S_IDLE: begin
          idx <= W_CTRL;
          // a halted engine restarts the walk from the base
          if (!rif.enable) cur_addr <= rif.base;
          else if (!error && !rif.error_clear) state <= S_FETCH_CTRL;
        end
        S_FETCH_CTRL: begin
          if (mem_ready) begin
            if (!owned) begin
              poll_cnt <= rif.poll;
              state <= S_POLL;
            end else if (mode_reserved) begin
              error <= 1'b1;
              state <= S_IDLE;
            end else begin
              idx <= W_ASSOC;
              state <= S_FETCH_REST;
            end
          end
        end
        S_POLL: begin
          if (poll_cnt == 16'h0000) state <= S_IDLE;
          else poll_cnt <= poll_cnt - 16'h0001;
        end
        S_FETCH_REST: begin
          if (mem_ready) begin
            if (last_word) begin
              op_start <= 1'b1;
              state <= S_RUN;
            end else begin
              idx <= idx + 3'h1;
            end
          end
        end
        S_RUN: begin
          if (op_done) begin
            filled <= op_filled_bytes;
            frame_end <= op_frame_end;
            result <= op_result;
            state <= S_POST;
          end
        end
        S_POST: begin
          idx <= W_CTRL;
          if (mem_ready) state <= S_WRITE_BACK;
        end
        S_WRITE_BACK: begin
          if (mem_ready) begin
            descriptor_done_irq <= ctrl[DESC_IRQ_BIT];
            packet_done_irq <= ctrl[PKT_IRQ_BIT] && packet_end;
            cur_addr <= next_addr;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // helper: cycles spent in the poll wait
  logic [16:0] wait_len;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) wait_len <= 17'h0_0000;
    else if (state == S_POLL) wait_len <= wait_len + 17'h0_0001;
    else wait_len <= 17'h0_0000;
  end

  // interval in force for this wait; software may rewrite the register meanwhile
  logic [15:0] poll_load;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) poll_load <= 16'h0000;
    else if (state == S_FETCH_CTRL && mem_ready && !owned) poll_load <= rif.poll;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  owner_cleared_a: assert property (
    state == S_WRITE_BACK |-> !mem_wdata[OWN_BIT])
    else $error("write-back keeps ownership set");
  chain_reload_a: assert property (
    state == S_WRITE_BACK && mem_ready && chain_end |=> cur_addr == $past(rif.base))
    else $error("chain end did not reload base");
  poll_length_a: assert property (
    state == S_POLL |-> wait_len <= {1'b0, poll_load})
    else $error("poll wait too long");
  poll_exit_a: assert property (
    state == S_POLL && wait_len == {1'b0, poll_load} |=> state == S_IDLE)
    else $error("poll wait did not end");
  unowned_wait_a: assert property (
    state == S_FETCH_CTRL && mem_ready && !owned |=> state == S_POLL && !op_start)
    else $error("unowned descriptor processed");
  reserved_mode_a: assert property (
    state == S_FETCH_CTRL && mem_ready && owned && mode_reserved
    |=> error && state == S_IDLE)
    else $error("reserved mode not flagged");
  desc_irq_a: assert property (
    descriptor_done_irq |-> $past(state) == S_WRITE_BACK && ctrl[DESC_IRQ_BIT])
    else $error("descriptor event without cause");
  packet_irq_a: assert property (
    packet_done_irq |-> ctrl[PKT_IRQ_BIT] && packet_end)
    else $error("packet event without packet end");
  post_address_a: assert property (
    state == S_POST |-> mem_write && mem_addr == desc[W_POST] && mem_wdata == result)
    else $error("result posted to wrong place");
  receive_length_a: assert property (
    state == S_WRITE_BACK && rif.receive |-> mem_wdata[LEN_HI:0] == filled)
    else $error("receive length not written");
  start_pulse_a: assert property (
    op_start |=> !op_start ##0 state == S_RUN)
    else $error("start is not a single pulse");
  // the eight words are read in rising address order
  fetch_order_a: assert property (
    state == S_FETCH_REST && mem_ready && !last_word
    |=> mem_addr == $past(mem_addr) + 32'h0000_0004)
    else $error("descriptor words out of order");
  chain_next_a: assert property (
    state == S_WRITE_BACK && mem_ready && !chain_end |=> cur_addr == $past(desc[W_NEXT]))
    else $error("next pointer not followed");
  frame_flag_a: assert property (
    state == S_WRITE_BACK && rif.receive |-> mem_wdata[FRAME_BIT] == frame_end)
    else $error("receive frame flag not written");
  mode_start_a: assert property (
    op_start |-> !ctrl[MODE_HI])
    else $error("reserved mode started");
  error_idle_a: assert property (
    error |-> state == S_IDLE)
    else $error("engine runs with error set");
  request_hold_a: assert property (
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request changed before taken");
endmodule : crypto_descriptor_processor

//--- sim/system_memory_model.sv
`timescale 1ns/1ps
module system_memory_model (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic mem_valid, // request from the engine
  input wire logic mem_write, // request is a write
  input wire logic [31:0] mem_addr, // byte address
  input wire logic [31:0] mem_wdata, // write data
  input wire logic [3:0] stall, // extra wait cycles per request
  output logic mem_ready, // request taken
  output logic [31:0] mem_rdata // read data, valid with ready
);
  // descriptors are placed here by the bench in place, engine updates them
  logic [31:0] words [0:255];
  logic [3:0] waited;
  wire logic [7:0] idx = mem_addr[9:2];
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_ready <= 1'b0;
      mem_rdata <= 32'h5A5A_A5A5;
      waited <= 4'h0;
    end else begin
      mem_ready <= 1'b0;
      // off-cycle data keeps toggling so a read taken at the wrong edge shows
      mem_rdata <= ~mem_rdata;
      if (mem_valid && !mem_ready) begin
        waited <= waited + 4'h1;
        if (waited >= stall) begin
          waited <= 4'h0;
          mem_ready <= 1'b1;
          if (mem_write) words[idx] <= mem_wdata;
          else mem_rdata <= words[idx];
        end
      end
    end
  end
endmodule : system_memory_model

//--- sim/tb_crypto_descriptor_processor.sv
`timescale 1ns/1ps
module tb_crypto_descriptor_processor;
  import cdp_pkg::*;
  logic clock, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mem_valid, mem_write, mem_ready;
  logic op_start, op_fetch_association, op_done, op_frame_end;
  logic descriptor_done_irq, packet_done_irq;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb, stall, strb;
  logic [1:0] bresp, rresp, r;
  logic [31:0] wdata, rdata, mem_addr, mem_wdata, mem_rdata, op_result, q;
  logic [31:0] op_association_pointer, op_source_pointer, op_destination_pointer;
  logic [31:0] op_total_message_bytes, op_cipher_offset;
  logic [15:0] op_buffer_length, op_filled_bytes;
  crypto_operation_type op_mode;
  int n_errors, n_tests, n_starts, n_dirq, n_pirq, cyc, last_rd, gap, d, p, s, g3;
  crypto_descriptor_processor u_crypto_descriptor_processor (
    .clock, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .mem_valid, .mem_write, .mem_addr, .mem_wdata, .mem_ready, .mem_rdata, .op_start,
    .op_mode, .op_fetch_association, .op_association_pointer, .op_source_pointer,
    .op_destination_pointer, .op_buffer_length, .op_total_message_bytes, .op_cipher_offset,
    .op_done, .op_filled_bytes, .op_frame_end, .op_result, .descriptor_done_irq,
    .packet_done_irq);
  system_memory_model u_system_memory_model (
    .clock, .rst_n, .mem_valid, .mem_write, .mem_addr, .mem_wdata, .stall, .mem_ready,
    .mem_rdata);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // outputs are looked at mid-cycle, where they have settled
  always @(negedge clock) begin
    cyc <= cyc + 1;
    if (op_start === 1'b1) n_starts <= n_starts + 1;
    if (descriptor_done_irq === 1'b1) n_dirq <= n_dirq + 1;
    if (packet_done_irq === 1'b1) n_pirq <= n_pirq + 1;
    if (mem_valid === 1'b1 && mem_ready === 1'b1 && mem_write === 1'b0
        && mem_addr[4:0] === 5'h00) begin
      gap <= cyc - last_rd;
      last_rd <= cyc;
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [31:0] mw(input logic [31:0] a);
    return u_system_memory_model.words[a[9:2]];
  endfunction : mw
  task axi(input bit wr, input logic [7:0] a, input logic [31:0] dat);
    bit ha, hw, har, hb;
    @(posedge clock);
    if (wr) begin
      awaddr <= a;
      wdata <= dat;
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    hb = 1'b0;
    while (!hb) begin
      @(negedge clock);
      ha = awvalid && awready;
      hw = wvalid && wready;
      har = arvalid && arready;
      hb = (bvalid && bready) || (rvalid && rready);
      q = rdata;
      r = wr ? bresp : rresp;
      @(posedge clock);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (har) arvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
  endtask : axi
  task put_desc(input logic [31:0] a, c, nx, pp);
    for (int k = 0; k < 8; k++) begin
      u_system_memory_model.words[a[9:2] + k] = {4'(k), 12'h0A5, a[15:0]};
    end
    u_system_memory_model.words[a[9:2]] = c;
    u_system_memory_model.words[a[9:2] + 4] = nx;
    u_system_memory_model.words[a[9:2] + 5] = pp;
  endtask : put_desc
  // plays the datapath for one descriptor and judges its write-back
  task run_op(input logic [31:0] a, input logic [15:0] fill, input logic fe,
              input logic [31:0] res, input bit rx);
    logic [31:0] c, pp;
    int t;
    c = mw(a);
    pp = mw(a + 20);
    for (t = 0; t < 400 && op_start !== 1'b1; t++) @(negedge clock);
    check({31'h0, op_start}, 32'h1);
    check({29'h0, op_mode}, {29'h0, c[29:27]});
    check({31'h0, op_fetch_association}, {31'h0, c[22]});
    check(op_association_pointer, mw(a + 4));
    check(op_source_pointer, mw(a + 8));
    check(op_destination_pointer, mw(a + 12));
    check({16'h0, op_buffer_length}, {16'h0, c[15:0]});
    check(op_total_message_bytes, mw(a + 24));
    check(op_cipher_offset, mw(a + 28));
    @(posedge clock);
    op_done <= 1'b1;
    op_filled_bytes <= fill;
    op_frame_end <= fe;
    op_result <= res;
    @(posedge clock);
    op_done <= 1'b0;
    op_filled_bytes <= ~fill;
    op_frame_end <= ~fe;
    op_result <= ~res;
    for (t = 0; t < 400 && mw(a) !== {1'b0, c[30:0]} && mw(a) !== {1'b0, c[30:19], fe,
         c[17:16], fill}; t++) @(negedge clock);
    check(mw(pp), res);
    if (rx) check(mw(a), {1'b0, c[30:19], fe, c[17:16], fill});
    else check(mw(a), {1'b0, c[30:0]});
    repeat (3) @(negedge clock);
  endtask : run_op
  task s_regs;
    axi(0, OFS_BASE, 0);
    check(q, RST_BASE);
    axi(0, OFS_POLL, 0);
    check(q, {16'h0, RST_POLL});
    strb = 4'h1;
    axi(1, OFS_POLL, 32'h0000_FF05);
    strb = 4'hF;
    check({30'h0, r}, 32'h0);
    axi(0, OFS_POLL, 0);
    check(q, 32'h0000_0005);
    axi(1, OFS_BASE, 32'h0000_0040);
    axi(1, OFS_CURRENT, 32'h0000_0300);
    axi(0, OFS_CURRENT, 0);
    check(q, 32'h0000_0040);
    axi(1, 8'h1C, 32'h0000_0001);
    check({30'h0, r}, 32'h2);
    axi(0, 8'h1C, 0);
    check({q[31:2], r}, 32'h2);
  endtask : s_regs
  task s_single;
    put_desc(32'h0000_0040, 32'h884F_0010, 32'h0000_0000, 32'h0000_0200);
    d = n_dirq;
    p = n_pirq;
    axi(1, OFS_CONTROL, 32'h0000_0001);
    run_op(32'h0000_0040, 16'h0000, 1'b0, 32'hC0DE_0001, 1'b0);
    check(n_dirq - d, 1);
    check(n_pirq - p, 1);
    axi(0, OFS_CURRENT, 0);
    check(q, 32'h0000_0040);
  endtask : s_single
  // the base descriptor is now software-owned, so the engine keeps polling it
  task s_poll;
    s = n_starts;
    axi(1, OFS_POLL, 32'h0000_0003);
    repeat (40) @(negedge clock);
    g3 = gap;
    axi(1, OFS_POLL, 32'h0000_0007);
    repeat (60) @(negedge clock);
    check(gap - g3, 4);
    check(n_starts - s, 0);
  endtask : s_poll
  task s_chain_rx;
    axi(1, OFS_CONTROL, 32'h0000_0000);
    repeat (40) @(negedge clock);
    stall <= 4'h2;
    put_desc(32'h0000_0040, 32'h9043_0100, 32'h0000_0080, 32'h0000_0210);
    put_desc(32'h0000_0080, 32'h980A_0100, 32'h0000_0000, 32'h0000_0220);
    d = n_dirq;
    p = n_pirq;
    axi(1, OFS_CONTROL, 32'h0000_0003);
    run_op(32'h0000_0040, 16'h0033, 1'b0, 32'h1111_2222, 1'b1);
    check(n_dirq - d, 1);
    check(n_pirq - p, 0);
    run_op(32'h0000_0080, 16'h0044, 1'b1, 32'h3333_4444, 1'b1);
    check(n_dirq - d, 1);
    check(n_pirq - p, 1);
    stall <= 4'h0;
  endtask : s_chain_rx
  task s_reserved;
    axi(1, OFS_CONTROL, 32'h0000_0000);
    repeat (40) @(negedge clock);
    put_desc(32'h0000_0040, 32'hA008_0000, 32'h0000_0000, 32'h0000_0230);
    s = n_starts;
    axi(1, OFS_CONTROL, 32'h0000_0001);
    repeat (30) @(negedge clock);
    axi(0, OFS_STATUS, 0);
    check({31'h0, q[ST_ERROR_BIT]}, 32'h1);
    check(n_starts - s, 0);
    check(mw(32'h0000_0040), 32'hA008_0000);
    put_desc(32'h0000_0040, 32'h8009_0004, 32'h0000_0000, 32'h0000_0240);
    axi(1, OFS_STATUS, 32'h0000_0002);
    run_op(32'h0000_0040, 16'h0000, 1'b0, 32'h5555_6666, 1'b0);
    axi(0, OFS_STATUS, 0);
    check({31'h0, q[ST_ERROR_BIT]}, 32'h0);
  endtask : s_reserved
  task give_verdict;
    $display("errors %0d, comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, arvalid, bready, rready, op_done, op_frame_end} = '0;
    {awaddr, araddr, wdata, op_result, op_filled_bytes} = '0;
    wstrb = 4'hF;
    strb = 4'hF;
    stall = 4'h0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    s_regs();
    s_single();
    s_poll();
    s_chain_rx();
    s_reserved();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    give_verdict();
  end
endmodule : tb_crypto_descriptor_processor
